// file: pkg/ubc_pkg.sv
// constants and state encodings for the bus-emulation uart channel
package ubc_pkg;

    // ****************************************************************
    // mode, framing and timing
    // ****************************************************************
    localparam logic [2:0] UBC_MODE_BUS_EMU = 3'h6;
    localparam int UBC_DATA_BITS = 9;
    localparam int UBC_DIV_BITS = 8;
    localparam logic [3:0] UBC_PHASE_LAST = 4'hf;
    localparam logic [3:0] UBC_PHASE_RISE = 4'h8;
    localparam logic [3:0] UBC_PHASE_RX_SAMPLE = 4'h7;
    localparam logic [3:0] UBC_LAST_BIT = 4'h8;
    localparam logic [3:0] UBC_PHASE_INC = 4'h1;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [8:0] UBC_RST_DATA = 9'h000;
    localparam logic [3:0] UBC_RST_COUNT = 4'h0;
    localparam logic [7:0] UBC_RST_DIV = 8'h00;

    // ****************************************************************
    // state encodings
    // ****************************************************************
    typedef enum logic [3:0] {
        UBC_TX_IDLE = 4'h1,
        UBC_TX_START = 4'h2,
        UBC_TX_DATA = 4'h4,
        UBC_TX_STOP = 4'h8
    } ubc_tx_state_t;

    typedef enum logic [3:0] {
        UBC_RX_IDLE = 4'h1,
        UBC_RX_START = 4'h2,
        UBC_RX_DATA = 4'h4,
        UBC_RX_STOP = 4'h8
    } ubc_rx_state_t;

endpackage

// file: src/ubc_tick_gen.sv
// sixteen-times bit-rate tick from the baud divider or an external clock
`timescale 1ns/1ps

module ubc_tick_gen #(
    parameter int DIV_BITS = ubc_pkg::UBC_DIV_BITS
) (
    input wire logic clock,
    input wire logic rstN,
    input wire logic clockSourceSelect,
    input wire logic extClockLevel,
    input wire logic [DIV_BITS-1:0] baudDividerReg,
    output logic tick
);

    typedef struct packed {
        logic [DIV_BITS-1:0] count;
        logic extPrev;
        logic tick;
    } ubc_tick_state_t;

    ubc_tick_state_t s_q;
    ubc_tick_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.extPrev = extClockLevel;
        s_d.tick = 1'b0;
        if (clockSourceSelect) begin
            // external clock: one tick per rising edge of the synced level
            s_d.tick = extClockLevel & ~s_q.extPrev; // [R10]
        end else if (s_q.count == '0) begin
            s_d.count = baudDividerReg; // [R10]
            s_d.tick = 1'b1;
        end else begin
            s_d.count = s_q.count - {{(DIV_BITS-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstN);

    a_ext_tick_edge: assert property ($past(clockSourceSelect) && tick |-> // [R10]
        $past(extClockLevel))
        else $error("external tick without a rising clock edge");

endmodule

// file: src/ubc_channel.sv
// bus-emulation uart channel with transmit/receive collision detection
`timescale 1ns/1ps

// Contract
// [R1] each bus bit is sent or received as one whole asynchronous character.
// [R2] a mismatch between the driven transmit level and the sensed receive level raises a collision request.
// [R3] software enables the collision sources of channels 0 and 1 in the source select register.
// [R4] software sets the mode field to the bus-emulation code.
// [R5] transmit and receive data are nine bits wide and the receive side has overrun, framing, parity and sum flags.
// [R6] the receive data register shows overrun, framing, parity and a combined error-sum flag.
// [R7] the sample select bit picks the compare moment, with 0 meaning the rising edge of the transfer clock.
// [R8] with auto-clear enabled a detected collision clears the transmit enable.
// [R9] the start select bit decides which condition starts a character.
// [R10] the transfer clock comes from the baud divider or an external clock as chosen.
// [R11] the polarity bit inverts both the transmit output and the receive input.
// [R12] software programs one stop bit and no parity.
// [R13] software sets the handshake disable bit, so the handshake select is ignored.
// [R14] on channel 2 the transmit pin is always open-drain.
// [R15] software writes 0 to bits 4 and 5 of the channel 0 and 1 control registers.
// [R16] software writes 0 to all configuration bits without a function in this mode.
// [R17] a detected collision stays latched until software services it.
module ubc_channel #(
    parameter bit OPEN_DRAIN_TX = 1'b0,
    parameter int DIV_BITS = ubc_pkg::UBC_DIV_BITS
) (
    input wire logic clock,
    input wire logic rst_b,
    output logic serialTxPinOut,
    output logic serialTxPinOe,
    input wire logic serialRxPin,
    input wire logic extClockPin,
    input wire logic clockSourceSelect,
    input wire logic [DIV_BITS-1:0] baudDividerReg,
    input wire logic [2:0] serialModeField,
    input wire logic linePolarityInvert,
    input wire logic collisionSampleSelect,
    input wire logic txEnableAutoclear,
    input wire logic txStartConditionSelect,
    input wire logic rxEnable,
    input wire logic txEnableSet,
    input wire logic txEnableClear,
    input wire logic [8:0] txDataReg,
    input wire logic txDataWrite,
    input wire logic rxDataRead,
    input wire logic collisionClear,
    output logic [8:0] rxDataReg,
    output logic overrunErrorFlag,
    output logic framingErrorFlag,
    output logic parityErrorFlag,
    output logic errorSumFlag,
    output logic rxCompleteFlag,
    output logic txBufferEmptyFlag,
    output logic txShiftEmptyFlag,
    output logic txEnable,
    output logic collisionFlag,
    output logic collisionIrq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic rxMeta;
        logic rxSync;
        logic rxPrev;
        logic extMeta;
        logic extSync;
        ubc_pkg::ubc_tx_state_t txState;
        logic [3:0] txPhase;
        logic [3:0] txBitCnt;
        logic [8:0] txShift;
        logic txLine;
        logic [8:0] txBuf;
        logic txBufFull;
        logic txEnable;
        ubc_pkg::ubc_rx_state_t rxState;
        logic [3:0] rxPhase;
        logic [3:0] rxBitCnt;
        logic [8:0] rxShift;
        logic [8:0] rxData;
        logic rxDone;
        logic overrun;
        logic framing;
        logic rxStartSeen;
        logic collision;
    } ubc_state_t;

    ubc_state_t s_q;
    ubc_state_t s_d;
    logic rstMeta;
    logic rstSync;
    logic tick;
    logic rxLevel;
    logic [3:0] colPhase;
    logic colHit;
    logic txLoad;
    logic pinLevel;

    // ****************************************************************
    // reset release
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    ubc_tick_gen #(
        .DIV_BITS(DIV_BITS)
    ) u_tick (
        .clock(clock),
        .rstN(rstSync),
        .clockSourceSelect(clockSourceSelect),
        .extClockLevel(s_q.extSync),
        .baudDividerReg(baudDividerReg),
        .tick(tick)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    assign rxLevel = s_q.rxSync ^ linePolarityInvert; // [R11]
    // 0 compares at the rising edge, mid-bit; 1 compares at the bit's end
    assign colPhase = collisionSampleSelect ? ubc_pkg::UBC_PHASE_LAST
                                            : ubc_pkg::UBC_PHASE_RISE; // [R7]
    assign txLoad = (s_q.txState == ubc_pkg::UBC_TX_IDLE) && s_q.txBufFull && s_q.txEnable
                    && (!txStartConditionSelect || s_q.rxStartSeen); // [R9]
    // the rx path lags the tx line by the synchroniser, far less than half a bit
    assign colHit = tick && (s_q.txState != ubc_pkg::UBC_TX_IDLE)
                    && (serialModeField == ubc_pkg::UBC_MODE_BUS_EMU)
                    && (s_q.txPhase == colPhase) && (s_q.txLine != rxLevel); // [R2]

    always_comb begin
        s_d = s_q;
        s_d.rxMeta = serialRxPin;
        s_d.rxSync = s_q.rxMeta;
        s_d.extMeta = extClockPin;
        s_d.extSync = s_q.extMeta;
        s_d.rxPrev = rxLevel;

        if (txEnableClear) begin
            s_d.txEnable = 1'b0;
        end
        if (txEnableSet) begin
            s_d.txEnable = 1'b1;
        end

        // transmitter: start, nine data bits, one stop bit
        if (txLoad) begin
            s_d.txState = ubc_pkg::UBC_TX_START; // [R1]
            s_d.txPhase = ubc_pkg::UBC_RST_COUNT;
            s_d.txShift = s_q.txBuf;
            s_d.txLine = 1'b0;
            s_d.txBufFull = 1'b0;
            s_d.rxStartSeen = 1'b0;
        end else if (tick && s_q.txState != ubc_pkg::UBC_TX_IDLE) begin
            s_d.txPhase = s_q.txPhase + ubc_pkg::UBC_PHASE_INC;
            if (s_q.txPhase == ubc_pkg::UBC_PHASE_LAST) begin
                unique case (s_q.txState)
                    ubc_pkg::UBC_TX_START: begin
                        s_d.txState = ubc_pkg::UBC_TX_DATA;
                        s_d.txBitCnt = ubc_pkg::UBC_RST_COUNT;
                        s_d.txLine = s_q.txShift[0];
                    end
                    ubc_pkg::UBC_TX_DATA: begin
                        s_d.txShift = {1'b0, s_q.txShift[8:1]};
                        s_d.txBitCnt = s_q.txBitCnt + ubc_pkg::UBC_PHASE_INC;
                        if (s_q.txBitCnt == ubc_pkg::UBC_LAST_BIT) begin
                            s_d.txState = ubc_pkg::UBC_TX_STOP; // [R1]
                            s_d.txLine = 1'b1;
                        end else begin
                            s_d.txLine = s_q.txShift[1];
                        end
                    end
                    ubc_pkg::UBC_TX_STOP: begin
                        s_d.txState = ubc_pkg::UBC_TX_IDLE;
                    end
                    default: begin
                        s_d.txState = ubc_pkg::UBC_TX_IDLE;
                        s_d.txLine = 1'b1;
                    end
                endcase
            end
        end
        if (txDataWrite) begin
            s_d.txBuf = txDataReg; // [R5]
            s_d.txBufFull = 1'b1;
        end

        // collision: sticky, the new event beats a clear in the same cycle
        if (collisionClear) begin
            s_d.collision = 1'b0;
        end
        if (colHit) begin
            s_d.collision = 1'b1; // [R17]
            if (txEnableAutoclear) begin
                // losing node backs off at once so the bus stays with the winner
                s_d.txEnable = 1'b0; // [R8]
                s_d.txState = ubc_pkg::UBC_TX_IDLE;
                s_d.txLine = 1'b1;
            end
        end

        // receiver
        if (rxDataRead) begin
            s_d.rxDone = 1'b0;
            s_d.overrun = 1'b0;
            s_d.framing = 1'b0;
        end
        unique case (s_q.rxState)
            ubc_pkg::UBC_RX_IDLE: begin
                if (rxEnable && s_q.rxPrev && !rxLevel) begin
                    s_d.rxState = ubc_pkg::UBC_RX_START;
                    s_d.rxPhase = ubc_pkg::UBC_RST_COUNT;
                end
            end
            ubc_pkg::UBC_RX_START: begin
                if (tick) begin
                    s_d.rxPhase = s_q.rxPhase + ubc_pkg::UBC_PHASE_INC;
                    if (s_q.rxPhase == ubc_pkg::UBC_PHASE_RX_SAMPLE && rxLevel) begin
                        s_d.rxState = ubc_pkg::UBC_RX_IDLE;
                    end else if (s_q.rxPhase == ubc_pkg::UBC_PHASE_LAST) begin
                        s_d.rxState = ubc_pkg::UBC_RX_DATA;
                        s_d.rxBitCnt = ubc_pkg::UBC_RST_COUNT;
                        // a start bit that held opens the tx gate
                        s_d.rxStartSeen = 1'b1; // [R9]
                    end
                end
            end
            ubc_pkg::UBC_RX_DATA: begin
                if (tick) begin
                    s_d.rxPhase = s_q.rxPhase + ubc_pkg::UBC_PHASE_INC;
                    if (s_q.rxPhase == ubc_pkg::UBC_PHASE_RX_SAMPLE) begin
                        s_d.rxShift = {rxLevel, s_q.rxShift[8:1]}; // [R1]
                    end
                    if (s_q.rxPhase == ubc_pkg::UBC_PHASE_LAST) begin
                        s_d.rxBitCnt = s_q.rxBitCnt + ubc_pkg::UBC_PHASE_INC;
                        if (s_q.rxBitCnt == ubc_pkg::UBC_LAST_BIT) begin
                            s_d.rxState = ubc_pkg::UBC_RX_STOP;
                        end
                    end
                end
            end
            ubc_pkg::UBC_RX_STOP: begin
                if (tick) begin
                    s_d.rxPhase = s_q.rxPhase + ubc_pkg::UBC_PHASE_INC;
                    // finish mid stop bit so the next start edge is not missed
                    if (s_q.rxPhase == ubc_pkg::UBC_PHASE_RX_SAMPLE) begin
                        s_d.rxState = ubc_pkg::UBC_RX_IDLE;
                        s_d.rxData = s_q.rxShift; // [R5]
                        s_d.framing = !rxLevel; // [R6]
                        s_d.overrun = (s_q.rxDone && !rxDataRead) || (s_q.overrun && !rxDataRead);
                        s_d.rxDone = 1'b1;
                    end
                end
            end
            default: begin
                s_d.rxState = ubc_pkg::UBC_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            s_q <= '0;
            s_q.txState <= ubc_pkg::UBC_TX_IDLE;
            s_q.rxState <= ubc_pkg::UBC_RX_IDLE;
            s_q.txLine <= 1'b1;
            s_q.rxPrev <= 1'b1;
            s_q.txBuf <= ubc_pkg::UBC_RST_DATA;
            s_q.rxData <= ubc_pkg::UBC_RST_DATA;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign pinLevel = s_q.txLine ^ linePolarityInvert; // [R11]
    // open-drain only pulls low; the bus resistor makes the high level
    assign serialTxPinOut = OPEN_DRAIN_TX ? 1'b0 : pinLevel; // [R14]
    assign serialTxPinOe = OPEN_DRAIN_TX ? !pinLevel : 1'b1; // [R14]
    assign rxDataReg = s_q.rxData;
    assign overrunErrorFlag = s_q.overrun;
    assign framingErrorFlag = s_q.framing;
    // parity is never enabled in this mode
    assign parityErrorFlag = 1'b0;
    assign errorSumFlag = s_q.overrun | s_q.framing; // [R6]
    assign rxCompleteFlag = s_q.rxDone;
    assign txBufferEmptyFlag = !s_q.txBufFull;
    assign txShiftEmptyFlag = (s_q.txState == ubc_pkg::UBC_TX_IDLE);
    assign txEnable = s_q.txEnable;
    assign collisionFlag = s_q.collision;
    assign collisionIrq = s_q.collision; // [R2]

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstSync);

    a_collision_raises_flag: assert property (colHit |=> collisionFlag && collisionIrq) // [R2]
        else $error("collision not flagged");
    a_collision_flag_sticky: assert property (collisionFlag && !collisionClear |=> collisionFlag) // [R17]
        else $error("collision flag lost without clear");
    a_flag_needs_cause: assert property ($rose(collisionFlag) |-> $past(txShiftEmptyFlag) == 1'b0
        && $past(s_q.txPhase) == $past(colPhase)
        && $past(serialModeField) == ubc_pkg::UBC_MODE_BUS_EMU) // [R7]
        else $error("collision flagged at wrong sample point");
    a_autoclear_drops_te: assert property (colHit && txEnableAutoclear |=> !txEnable
        && txShiftEmptyFlag) // [R8]
        else $error("transmit enable not auto-cleared");
    a_start_bit_low: assert property ($fell(txShiftEmptyFlag) |-> !s_q.txLine
        && s_q.txState == ubc_pkg::UBC_TX_START) // [R1]
        else $error("character did not begin with a start bit");
    a_stop_bit_high: assert property (s_q.txState == ubc_pkg::UBC_TX_STOP |-> s_q.txLine) // [R1]
        else $error("stop bit not high");
    a_start_condition: assert property ($fell(txShiftEmptyFlag) && $past(txStartConditionSelect)
        |-> $past(s_q.rxStartSeen) && $past(txEnable)) // [R9]
        else $error("transmit started without its start condition");
    a_error_sum: assert property (errorSumFlag == (overrunErrorFlag | framingErrorFlag
        | parityErrorFlag)) // [R6]
        else $error("error sum disagrees with error flags");
    a_idle_line_level: assert property (txShiftEmptyFlag && !OPEN_DRAIN_TX |->
        serialTxPinOut == !linePolarityInvert) // [R11]
        else $error("idle transmit level wrong for polarity");
    a_open_drain_tx: assert property (OPEN_DRAIN_TX |-> !serialTxPinOut) // [R14]
        else $error("open-drain pin driven high");
    a_rx_data_capture: assert property ($rose(rxCompleteFlag) |-> rxDataReg == $past(s_q.rxShift)) // [R5]
        else $error("received data not captured");

    c_collision_seen: cover property (colHit);
    c_autoclear_seen: cover property (colHit && txEnableAutoclear);
    c_frame_received: cover property ($rose(rxCompleteFlag));
    c_overrun_seen: cover property ($rose(overrunErrorFlag));

endmodule

// file: sim/ubc_bus_node.sv
// behavioural model of another node on the shared wired-and serial line
`timescale 1ns/1ps

module ubc_bus_node (
    input wire logic clock,
    input wire logic dutPin,
    input wire logic invert,
    input wire logic forceDom,
    input wire logic sendReq,
    input wire logic [8:0] sendData,
    input wire logic badStop,
    input wire logic [7:0] bitClocks,
    output logic rxPin,
    output logic nodeBusy
);
    // ****************************************************************
    // line and frame
    // ****************************************************************
    logic nodeLvl;
    logic [10:0] frame;

    initial begin
        nodeLvl = 1'b1;
        nodeBusy = 1'b0;
    end

    // one character per bus bit: start, nine data lsb first, one stop, no parity
    always @(posedge clock) begin
        if (sendReq && !nodeBusy) begin
            nodeBusy <= 1'b1;
            frame = {~badStop, sendData, 1'b0};
            for (int i = 0; i < 11; i++) begin
                nodeLvl <= frame[i];
                repeat (bitClocks) @(posedge clock);
            end
            nodeLvl <= 1'b1;
            nodeBusy <= 1'b0;
        end
    end

    // pull-up makes a released line recessive; any low driver dominates
    assign rxPin = ((dutPin ^ invert) & nodeLvl & ~forceDom) ^ invert;
endmodule

// file: sim/ubc_channel_test.sv
// self-checking bench for the bus-emulation uart channel
`timescale 1ns/1ps

module ubc_channel_test;
    logic clock = 1'b0, rst_b = 1'b0, serialTxPinOut, serialTxPinOe, serialRxPin;
    logic extClockPin = 1'b0, clockSourceSelect = 1'b0, linePolarityInvert = 1'b0;
    logic collisionSampleSelect = 1'b0, txEnableAutoclear = 1'b0;
    logic txStartConditionSelect = 1'b0, rxEnable = 1'b1, txEnableSet = 1'b0;
    logic txEnableClear = 1'b0, txDataWrite = 1'b0, rxDataRead = 1'b0;
    logic collisionClear = 1'b0, forceDom = 1'b0, sendReq = 1'b0, badStop = 1'b0;
    logic [7:0] baudDividerReg = 8'h01;
    logic [2:0] serialModeField = 3'h6;
    // held outside: sources on, handshake off, spares 0
    logic [2:0] extCnt = 3'h0;
    logic [8:0] txDataReg = 9'h000, sendData = 9'h000, rxDataReg;
    logic overrunErrorFlag, framingErrorFlag, parityErrorFlag, errorSumFlag, nodeBusy;
    logic rxCompleteFlag, txBufferEmptyFlag, txShiftEmptyFlag, txEnable;
    logic collisionFlag, collisionIrq;
    int bad_count = 0, n_tests = 0, lowLen;

    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        extCnt <= extCnt + 3'h1;
        extClockPin <= extCnt[2];
    end

    ubc_channel u_ubc_channel (.clock(clock), .rst_b(rst_b), .serialTxPinOut(serialTxPinOut),
        .serialTxPinOe(serialTxPinOe), .serialRxPin(serialRxPin), .extClockPin(extClockPin),
        .clockSourceSelect(clockSourceSelect), .baudDividerReg(baudDividerReg),
        .serialModeField(serialModeField), .linePolarityInvert(linePolarityInvert),
        .collisionSampleSelect(collisionSampleSelect), .txEnableAutoclear(txEnableAutoclear),
        .txStartConditionSelect(txStartConditionSelect), .rxEnable(rxEnable),
        .txEnableSet(txEnableSet), .txEnableClear(txEnableClear), .txDataReg(txDataReg),
        .txDataWrite(txDataWrite), .rxDataRead(rxDataRead), .collisionClear(collisionClear),
        .rxDataReg(rxDataReg), .overrunErrorFlag(overrunErrorFlag),
        .framingErrorFlag(framingErrorFlag), .parityErrorFlag(parityErrorFlag),
        .errorSumFlag(errorSumFlag), .rxCompleteFlag(rxCompleteFlag),
        .txBufferEmptyFlag(txBufferEmptyFlag), .txShiftEmptyFlag(txShiftEmptyFlag),
        .txEnable(txEnable), .collisionFlag(collisionFlag), .collisionIrq(collisionIrq));

    ubc_bus_node u_ubc_bus_node (.clock(clock), .dutPin(serialTxPinOut),
        .invert(linePolarityInvert), .forceDom(forceDom), .sendReq(sendReq),
        .sendData(sendData), .badStop(badStop), .bitClocks(8'h20), .rxPin(serialRxPin),
        .nodeBusy(nodeBusy));

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check9(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask

    // 0 enable set, 1 enable clear, 2 receive read, 3 collision clear
    task automatic pulse(input int which);
        @(posedge clock);
        case (which)
            0: txEnableSet <= 1'b1;
            1: txEnableClear <= 1'b1;
            2: rxDataRead <= 1'b1;
            default: collisionClear <= 1'b1;
        endcase
        @(posedge clock);
        txEnableSet <= 1'b0;
        txEnableClear <= 1'b0;
        rxDataRead <= 1'b0;
        collisionClear <= 1'b0;
        #1;
    endtask

    task automatic write_tx(input logic [8:0] d);
        @(posedge clock);
        txDataReg <= d;
        txDataWrite <= 1'b1;
        @(posedge clock);
        txDataWrite <= 1'b0;
        #1;
    endtask

    function automatic logic pick(input int which);
        return (which == 0) ? serialTxPinOut : (which == 1) ? txShiftEmptyFlag : nodeBusy;
    endfunction

    // bounded wait: 0 tx pin, 1 shift empty, 2 node busy
    task automatic wait_for(input int which, input logic lvl);
        int k;
        for (k = 0; k < 4000 && pick(which) !== lvl; k++) step(1);
        if (k == 4000) check1("wait target", lvl, pick(which));
    endtask

    task automatic node_send(input logic [8:0] d, input logic bad, input bit hold);
        @(posedge clock);
        sendData <= d;
        badStop <= bad;
        sendReq <= 1'b1;
        @(posedge clock);
        sendReq <= 1'b0;
        #1;
        if (hold) wait_for(2, 1'b0);
        step(2);
    endtask

    task automatic measure_low(output int n);
        wait_for(0, 1'b0);
        n = 0;
        while (serialTxPinOut === 1'b0 && n < 3000) begin
            step(1);
            n++;
        end
    endtask

    task automatic give_verdict;
        $display("mismatches %0d of %0d comparisons", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        give_verdict();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        logic [10:0] frame;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        step(4);
        check1("buffer empty", 1'b1, txBufferEmptyFlag);
        check1("shift empty", 1'b1, txShiftEmptyFlag);
        check1("tx enable", 1'b0, txEnable);
        check1("collision irq", 1'b0, collisionIrq);
        check1("tx idle", 1'b1, serialTxPinOut);
        check1("tx oe", 1'b1, serialTxPinOe);
        linePolarityInvert <= 1'b1;
        step(2);
        check1("inverted idle", 1'b0, serialTxPinOut);
        linePolarityInvert <= 1'b0;
        // start only after a receive start bit has been seen
        txStartConditionSelect <= 1'b1;
        write_tx(9'h1a5);
        pulse(0);
        check1("tx enable", 1'b1, txEnable);
        check1("buffer full", 1'b0, txBufferEmptyFlag);
        step(200);
        check1("held start", 1'b1, txShiftEmptyFlag);
        node_send(9'h1a5, 1'b0, 1'b0);
        step(50);
        check1("started", 1'b0, txShiftEmptyFlag);
        wait_for(1, 1'b1);
        wait_for(2, 1'b0);
        txStartConditionSelect <= 1'b0;
        step(40);
        pulse(2);
        pulse(3);
        // loopback character on the line, echoed into the receiver
        frame = {1'b1, 9'h0b6, 1'b0};
        write_tx(9'h0b6);
        wait_for(0, 1'b0);
        step(16);
        for (int i = 0; i < 11; i++) begin
            check1("line bit", frame[i], serialTxPinOut);
            step(32);
        end
        wait_for(1, 1'b1);
        step(40);
        check9("rx data", 9'h0b6, rxDataReg);
        check1("rx complete", 1'b1, rxCompleteFlag);
        check1("error sum", 1'b0, errorSumFlag);
        check1("parity flag", 1'b0, parityErrorFlag);
        check1("no collision", 1'b0, collisionFlag);
        pulse(2);
        write_tx(9'h000);
        measure_low(lowLen);
        check_range("internal low span", 316, 324, lowLen);
        wait_for(1, 1'b1);
        pulse(1);
        check1("tx disabled", 1'b0, txEnable);
        // receive errors: overrun then framing
        step(40);
        pulse(2);
        node_send(9'h0c3, 1'b0, 1'b1);
        check9("rx data", 9'h0c3, rxDataReg);
        check1("framing", 1'b0, framingErrorFlag);
        node_send(9'h155, 1'b1, 1'b1);
        check9("rx overwritten", 9'h155, rxDataReg);
        check1("overrun", 1'b1, overrunErrorFlag);
        check1("framing", 1'b1, framingErrorFlag);
        check1("error sum", 1'b1, errorSumFlag);
        step(40);
        pulse(2);
        check1("read clears", 1'b0, rxCompleteFlag);
        check1("sum cleared", 1'b0, errorSumFlag);
        // late dominant pulse inside a recessive bit: only the bit-end sample sees it
        txEnableAutoclear <= 1'b1;
        pulse(0);
        for (int s = 0; s < 2; s++) begin
            collisionSampleSelect <= s[0];
            write_tx(9'h1ff);
            wait_for(0, 1'b0);
            step(84);
            forceDom <= 1'b1;
            step(16);
            forceDom <= 1'b0;
            check1("collision", s[0], collisionFlag);
            check1("collision irq", s[0], collisionIrq);
            check1("tx enable", ~s[0], txEnable);
            wait_for(1, 1'b1);
        end
        step(100);
        check1("sticky", 1'b1, collisionFlag);
        pulse(3);
        check1("cleared", 1'b0, collisionFlag);
        pulse(2);
        // external transfer clock: one tick per rising edge, eight clocks apart
        clockSourceSelect <= 1'b1;
        pulse(0);
        write_tx(9'h000);
        measure_low(lowLen);
        check_range("external low span", 1268, 1292, lowLen);
        wait_for(1, 1'b1);
        give_verdict();
    end
endmodule
